/* File: core/cwk_option_ctrl.sv */
// option register, comparator control, path shutoff, shipping and wakeup
`timescale 1ns/1ps
module cwk_option_ctrl #(
    parameter int unsigned DEG_MID_CYC  = cwk_pkg::CWK_DEG_MID_CYC,
    parameter int unsigned DEG_LONG_CYC = cwk_pkg::CWK_DEG_LONG_CYC,
    parameter int unsigned SHIP_CYC     = cwk_pkg::CWK_SHIP_CYC,
    parameter int unsigned CYC_PER_MS   = cwk_pkg::CWK_CYC_PER_MS,
    parameter int unsigned WAKE_MS      = cwk_pkg::CWK_WAKE_MS
) (
    input  wire logic               clock_i,
    input  wire logic               arst_n_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic               reg_wr_i,
    input  wire logic [15:0]        reg_wdata_i,
    input  wire logic               reg_rd_i,
    output logic      [15:0]        reg_rdata_o,
    output logic                    reg_rvalid_o,
    input  wire cwk_pkg::cwk_sense_t sense_i,
    output logic                    comparator_output_o,
    output logic                    comparator_reference_sel_o,
    output logic                    input_high_switch_off_o,
    output logic                    output_high_switch_off_o,
    output logic                    charger_good_flag_o,
    output logic                    battery_sense_node_dischg_o,
    output logic                    wakeup_charge_en_o
);
    import cwk_pkg::*;

    typedef enum logic [2:0] {
        CWK_WK_IDLE    = 3'b001,
        CWK_WK_CHARGE  = 3'b010,
        CWK_WK_EXPIRED = 3'b100
    } cwk_wake_st_t;

    logic [15:0]   opt_r;
    cwk_opt_lo_t   cfg;
    logic          opt_wr;
    cwk_sense_t    sync1_r;
    cwk_sense_t    sync2_r;
    logic          cmp_en;
    logic          raw_high;
    logic [31:0]   deg_limit;
    logic          cmp_out_high;
    logic          latched_r;
    logic          latched_nxt;
    logic [31:0]   ship_cnt_r;
    logic          ship_done;
    logic [31:0]   ms_cnt_r;
    logic          ms_tick;
    logic [31:0]   wake_cnt_r;
    cwk_wake_st_t  wake_st_r;
    logic          wake_clear;

    assign cfg    = cwk_opt_lo_t'(opt_r[7:0]);
    assign opt_wr = reg_wr_i && (reg_addr_i == CWK_OPT_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // pin levels cross in through two flops
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= sense_i;
            sync2_r <= sync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // option register; host writes win over self-clearing
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opt_r <= CWK_OPT_RESET;
        end else if (opt_wr) begin
            opt_r <= reg_wdata_i;
        end else begin
            if (ship_done) begin
                opt_r[CWK_SHIP_POS] <= 1'b0;
            end
            if (wake_clear) begin
                opt_r[CWK_WAKE_POS] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o  <= 16'h0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i && reg_addr_i == CWK_OPT_ADDR) begin
                reg_rdata_o <= opt_r;
            end else begin
                reg_rdata_o <= 16'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // comparator: polarity, enable and deglitch selection
    assign cmp_en = (cfg.deg != CWK_DEG_OFF);
    // raw high means the output would be released high
    assign raw_high = cfg.pol ? sync2_r.cmp_above
                              : !sync2_r.cmp_above;

    always_comb begin
        case (cfg.deg)
            CWK_DEG_SHORT: deg_limit = CWK_DEG_SHORT_CYC;
            CWK_DEG_MID:   deg_limit = DEG_MID_CYC;
            CWK_DEG_LONG:  deg_limit = DEG_LONG_CYC;
            default:       deg_limit = CWK_DEG_SHORT_CYC;
        endcase
    end

    cwk_fall_deglitch u_deglitch (
        .clock_i    (clock_i),
        .arst_n_i   (arst_n_i),
        .enable_i   (cmp_en),
        .raw_high_i (raw_high),
        .limit_i    (deg_limit),
        .out_high_o (cmp_out_high)
    );

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            comparator_reference_sel_o <= 1'b0;
        end else begin
            comparator_reference_sel_o <= cfg.ref_sel;
        end
    end

    assign comparator_output_o = cmp_out_high;

    ////////////////////////////////////////////////////////////////////////
    // forced path shutoff; held until software clears the enable
    always_comb begin
        latched_nxt = latched_r;
        if (!cfg.shut_en) begin
            latched_nxt = 1'b0;
        end
        if (cfg.shut_en && cmp_en && !cmp_out_high) begin
            latched_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            latched_r                <= 1'b0;
            input_high_switch_off_o  <= 1'b0;
            output_high_switch_off_o <= 1'b0;
            charger_good_flag_o      <= 1'b0;
        end else begin
            latched_r                <= latched_nxt;
            input_high_switch_off_o  <= latched_nxt;
            output_high_switch_off_o <= latched_nxt;
            charger_good_flag_o      <= sync2_r.chg_good_src
                                        && !latched_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shipping discharge; a rewrite of one restarts the interval
    assign ship_done = cfg.ship && (ship_cnt_r >= SHIP_CYC - 32'h1);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ship_cnt_r                  <= 32'h0;
            battery_sense_node_dischg_o <= 1'b0;
        end else begin
            if (!cfg.ship || opt_wr || ship_done) begin
                ship_cnt_r <= 32'h0;
            end else begin
                ship_cnt_r <= ship_cnt_r + 32'h1;
            end
            battery_sense_node_dischg_o <= cfg.ship && !ship_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // millisecond enable for the long wakeup window
    assign ms_tick = (ms_cnt_r == CYC_PER_MS - 32'h1);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ms_cnt_r <= 32'h0;
        end else if (ms_tick || wake_st_r != CWK_WK_CHARGE) begin
            ms_cnt_r <= 32'h0;
        end else begin
            ms_cnt_r <= ms_cnt_r + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // auto wakeup precharge
    assign wake_clear = (wake_st_r == CWK_WK_CHARGE)
                        && !sync2_r.bat_below_min;

    // after timeout it waits for a rewrite or the battery to recover
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wake_st_r  <= CWK_WK_IDLE;
            wake_cnt_r <= 32'h0;
        end else begin
            case (wake_st_r)
                CWK_WK_IDLE: begin
                    wake_cnt_r <= 32'h0;
                    if (cfg.wake && sync2_r.bat_below_min) begin
                        wake_st_r <= CWK_WK_CHARGE;
                    end
                end
                CWK_WK_CHARGE: begin
                    if (!cfg.wake || wake_clear) begin
                        wake_st_r <= CWK_WK_IDLE;
                    end else if (ms_tick) begin
                        if (wake_cnt_r >= WAKE_MS - 32'h1) begin
                            wake_st_r <= CWK_WK_EXPIRED;
                        end
                        wake_cnt_r <= wake_cnt_r + 32'h1;
                    end
                end
                CWK_WK_EXPIRED: begin
                    if (opt_wr || !cfg.wake || !sync2_r.bat_below_min) begin
                        wake_st_r <= CWK_WK_IDLE;
                    end
                end
                default: wake_st_r <= CWK_WK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wakeup_charge_en_o <= 1'b0;
        end else begin
            wakeup_charge_en_o <= (wake_st_r == CWK_WK_CHARGE)
                                  && !wake_clear && cfg.wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_DISABLED_HIGH: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        cfg.deg == CWK_DEG_OFF |=> comparator_output_o)
        else $error("disabled comparator drove its output low");

    AST_POL_CLEAR: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        !cfg.pol && !sync2_r.cmp_above |=> comparator_output_o)
        else $error("output low with input below threshold, polarity 0");

    AST_POL_SET: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        cfg.pol && sync2_r.cmp_above |=> comparator_output_o)
        else $error("output low with input above threshold, polarity 1");

    AST_SHUTOFF: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        cfg.shut_en && cmp_en && !comparator_output_o
        |=> input_high_switch_off_o && output_high_switch_off_o)
        else $error("switches not turned off after a trip");

    AST_CHG_GOOD_LOW: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        input_high_switch_off_o |-> !charger_good_flag_o)
        else $error("charger good high during shutoff");

    AST_SHUTOFF_IDLE: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        !cfg.shut_en |=> !input_high_switch_off_o)
        else $error("shutoff active with its enable cleared");

    AST_SHIP_CLEAR: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        ship_done && !opt_wr |=> !cfg.ship && !battery_sense_node_dischg_o)
        else $error("shipping bit not cleared at end of interval");

    AST_SHIP_DRIVE: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        $rose(cfg.ship) |-> ##1 battery_sense_node_dischg_o [*2])
        else $error("shipping discharge not driven");

    AST_WAKE_END: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        wake_clear && !opt_wr |=> !cfg.wake && !wakeup_charge_en_o)
        else $error("wakeup charge not ended on battery recovery");

    AST_WAKE_START: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        wake_st_r == CWK_WK_IDLE && cfg.wake && sync2_r.bat_below_min
        && !opt_wr ##1 sync2_r.bat_below_min && cfg.wake
        |=> wakeup_charge_en_o)
        else $error("wakeup charge not started");

    AST_REF_SEL: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        !opt_wr ##1 !opt_wr |-> comparator_reference_sel_o == cfg.ref_sel)
        else $error("reference select does not follow register");

endmodule

/* File: core/cwk_pkg.sv */
// constants and types for the comparator, shipping and wakeup option control
package cwk_pkg;

    // register reached by its command code
    localparam logic [7:0]  CWK_OPT_ADDR  = 8'h30;
    localparam logic [15:0] CWK_OPT_RESET = 16'h0211;

    // low-byte field positions
    localparam int CWK_WAKE_POS = 0;
    localparam int CWK_SHIP_POS = 1;
    localparam int CWK_RSVD_POS = 2;
    localparam int CWK_SHUT_POS = 3;
    localparam int CWK_DEG_POS  = 4;
    localparam int CWK_POL_POS  = 6;
    localparam int CWK_REF_POS  = 7;

    // deglitch selection codes
    localparam logic [1:0] CWK_DEG_OFF   = 2'h0;
    localparam logic [1:0] CWK_DEG_SHORT = 2'h1;
    localparam logic [1:0] CWK_DEG_MID   = 2'h2;
    localparam logic [1:0] CWK_DEG_LONG  = 2'h3;

    // timing: figures in their own unit, then cycle counts at the clock rate; the wakeup window goes to milliseconds
    localparam int unsigned CWK_CLK_MHZ       = 250;
    localparam int unsigned CWK_CYC_PER_MS    = 1000 * CWK_CLK_MHZ;
    localparam int unsigned CWK_DEG_SHORT_US  = 1;
    localparam int unsigned CWK_DEG_SHORT_CYC = CWK_DEG_SHORT_US * CWK_CLK_MHZ;
    localparam int unsigned CWK_DEG_MID_MS    = 2;
    localparam int unsigned CWK_DEG_MID_CYC   = CWK_DEG_MID_MS * CWK_CYC_PER_MS;
    localparam int unsigned CWK_DEG_LONG_S    = 5;
    localparam int unsigned CWK_DEG_LONG_CYC  =
        CWK_DEG_LONG_S * 1000 * CWK_CYC_PER_MS;
    localparam int unsigned CWK_SHIP_MS       = 140;
    localparam int unsigned CWK_SHIP_CYC      = CWK_SHIP_MS * CWK_CYC_PER_MS;
    localparam int unsigned CWK_WAKE_MIN      = 30;
    localparam int unsigned CWK_WAKE_MS       = CWK_WAKE_MIN * 60 * 1000;

    // low byte of the option register
    typedef struct packed {
        logic       ref_sel;
        logic       pol;
        logic [1:0] deg;
        logic       shut_en;
        logic       rsvd;
        logic       ship;
        logic       wake;
    } cwk_opt_lo_t;

    // asynchronous level inputs from pins and analog front end
    typedef struct packed {
        logic cmp_above;
        logic bat_below_min;
        logic chg_good_src;
    } cwk_sense_t;

endpackage

/* File: core/cwk_fall_deglitch.sv */
// falling-edge-only deglitch filter for the comparator output
`timescale 1ns/1ps
module cwk_fall_deglitch (
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    input  wire logic        enable_i,
    input  wire logic        raw_high_i,
    input  wire logic [31:0] limit_i,
    output logic             out_high_o
);
    import cwk_pkg::*;

    logic [31:0] cnt_r;

    // low must persist for the whole interval; any high restarts it
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r      <= 32'h0;
            out_high_o <= 1'b1;
        end else if (!enable_i || raw_high_i) begin
            cnt_r      <= 32'h0;
            out_high_o <= 1'b1;
        end else if (out_high_o) begin
            if (cnt_r >= limit_i - 32'h1) begin
                out_high_o <= 1'b0;
                cnt_r      <= 32'h0;
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_RISE_FAST: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        raw_high_i |=> out_high_o)
        else $error("comparator output rise was delayed");

    AST_FALL_NEEDS_LOW: assert property (@(posedge clock_i)
        disable iff (!arst_n_i)
        $fell(out_high_o) |-> !$past(raw_high_i) && !$past(raw_high_i, 2))
        else $error("comparator output fell without a persistent low");

    AST_RESTART: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        raw_high_i |=> cnt_r == 32'h0)
        else $error("deglitch timer did not restart");

endmodule

/* File: dv/cwk_host_model.sv */
// host controller model driving the option register strobe port
`timescale 1ns/1ps
module cwk_host_model (
    input  wire logic        clock_i,
    output logic      [7:0]  reg_addr_o,
    output logic             reg_wr_o,
    output logic      [15:0] reg_wdata_o,
    output logic             reg_rd_o
);
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 16'h0000;
        reg_rd_o    = 1'b0;
    end
    // one-cycle strobe; address and data are inverted afterwards so a late
    // sample never sees a stale copy of the request
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [15:0] d);
        @(posedge clock_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= wr;
        reg_rd_o    <= !wr;
        @(posedge clock_i);
        reg_wr_o    <= 1'b0;
        reg_rd_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask
endmodule

/* File: dv/cwk_option_ctrl_test.sv */
// self-checking bench for the option control block
`timescale 1ns/1ps
module cwk_option_ctrl_test;
    import cwk_pkg::*;
    localparam int unsigned MID = 20;
    localparam int unsigned LNG = 50;
    localparam int unsigned SHIP = 30;
    localparam int unsigned CPM = 4;
    localparam int unsigned WMS = 5;
    localparam logic [15:0] T = 16'h0001;
    logic        clock_i;
    logic        arst_n_i;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [15:0] reg_wdata;
    logic        reg_rd;
    logic [15:0] reg_rdata_o;
    logic        reg_rvalid_o;
    cwk_sense_t  sense;
    logic        cmp_o;
    logic        ref_o;
    logic        in_off_o;
    logic        out_off_o;
    logic        good_o;
    logic        dischg_o;
    logic        wake_o;
    logic [15:0] regv;
    logic [15:0] exp_q[$];
    int          mismatches;
    int          samples_checked;
    int          n;
    int          lim;

    cwk_host_model i_cwk_host_model (
        .clock_i     (clock_i),
        .reg_addr_o  (reg_addr),
        .reg_wr_o    (reg_wr),
        .reg_wdata_o (reg_wdata),
        .reg_rd_o    (reg_rd)
    );
    cwk_option_ctrl #(.DEG_MID_CYC(MID), .DEG_LONG_CYC(LNG),
        .SHIP_CYC(SHIP), .CYC_PER_MS(CPM), .WAKE_MS(WMS)) i_cwk_option_ctrl (
        .clock_i                     (clock_i),
        .arst_n_i                    (arst_n_i),
        .reg_addr_i                  (reg_addr),
        .reg_wr_i                    (reg_wr),
        .reg_wdata_i                 (reg_wdata),
        .reg_rd_i                    (reg_rd),
        .reg_rdata_o                 (reg_rdata_o),
        .reg_rvalid_o                (reg_rvalid_o),
        .sense_i                     (sense),
        .comparator_output_o         (cmp_o),
        .comparator_reference_sel_o  (ref_o),
        .input_high_switch_off_o     (in_off_o),
        .output_high_switch_off_o    (out_off_o),
        .charger_good_flag_o         (good_o),
        .battery_sense_node_dischg_o (dischg_o),
        .wakeup_charge_en_o          (wake_o)
    );

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic out_bit(input int s);
        case (s)
            0: return cmp_o;
            1: return dischg_o;
            default: return wake_o;
        endcase
    endfunction
    // counts falling edges until the chosen output reaches lvl, bounded
    task automatic wait_out(input int s, input logic lvl, input int max,
                            output int cnt);
        cnt = 0;
        do begin
            @(negedge clock_i);
            cnt++;
        end while (out_bit(s) !== lvl && cnt < max);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_cwk_host_model.access(1'b1, a, d);
        if (a == CWK_OPT_ADDR) regv = d;
    endtask
    task automatic rd(input logic [7:0] a);
        exp_q.push_back(a == CWK_OPT_ADDR ? regv : 16'h0000);
        i_cwk_host_model.access(1'b0, a, 16'h0000);
    endtask
    task automatic set_sense(input logic above, input logic below);
        @(posedge clock_i);
        sense.cmp_above     <= above;
        sense.bat_below_min <= below;
    endtask
    // trip the comparator and watch filter, shutoff and release
    task automatic trip(input logic pol, input logic [1:0] deg,
                        input logic shut);
        logic [15:0] e;
        e = shut ? 16'h0006 : T;
        lim = deg == 2'h1 ? CWK_DEG_SHORT_CYC : (deg == 2'h2 ? MID : LNG);
        set_sense(pol, 1'b0);
        wr(CWK_OPT_ADDR, {regv[15:8], 1'b0, pol, deg, shut, 3'h0});
        repeat (4) @(posedge clock_i);
        set_sense(!pol, 1'b0);
        wait_out(0, 1'b0, lim + 20, n);
        check("fall delay", 16'(n >= lim && n <= lim + 8), T);
        @(negedge clock_i);
        check("shutoff", 16'({in_off_o, out_off_o, good_o}), e);
        set_sense(pol, 1'b0);
        wait_out(0, 1'b1, 20, n);
        check("rise delay", 16'(n <= 4), T);
        check("shutoff held", 16'({in_off_o, out_off_o, good_o}), e);
        wr(CWK_OPT_ADDR, regv & 16'hFFF7);
        repeat (2) @(negedge clock_i);
        check("shutoff off", 16'({in_off_o, out_off_o, good_o}), T);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(negedge clock_i) begin
        if (reg_rvalid_o === 1'b1) begin
            check("read pending", 16'(exp_q.size() > 0), T);
            if (exp_q.size() > 0) begin
                check("read data", reg_rdata_o, exp_q.pop_front());
            end
        end
    end

    initial begin
        #100000;
        mismatches++;
        summarize();
    end

    initial begin
        void'($urandom(32'h87105A71));
        arst_n_i = 1'b0;
        sense = 3'h1;
        regv = CWK_OPT_RESET;
        repeat (12) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        // look between edges so the launching edge cannot race the check
        @(negedge clock_i);
        check("reset outputs", 16'({cmp_o, ref_o, in_off_o, dischg_o}), 16'h0008);
        rd(CWK_OPT_ADDR);
        rd(8'h31);
        wr(8'h31, 16'($urandom));
        wr(CWK_OPT_ADDR, {8'($urandom), 8'h91});
        repeat (2) @(negedge clock_i);
        check("reference", 16'(ref_o), T);
        rd(CWK_OPT_ADDR);
        for (int d = 1; d < 4; d++) begin
            for (int p = 0; p < 2; p++) begin
                trip(p[0], d[1:0], p[0]);
            end
        end
        wr(CWK_OPT_ADDR, {regv[15:8], 8'h00});
        set_sense(1'b1, 1'b0);
        wait_out(0, 1'b0, 300, n);
        check("disabled", 16'(cmp_o), T);
        set_sense(1'b0, 1'b0);
        wr(CWK_OPT_ADDR, {regv[15:8], 8'h20});
        repeat (3) begin
            set_sense(1'b1, 1'b0);
            repeat ($urandom_range(MID - 8, MID - 5)) @(posedge clock_i);
            @(negedge clock_i);
            check("glitch", 16'(cmp_o), T);
            set_sense(1'b0, 1'b0);
            repeat (3) @(posedge clock_i);
        end
        wr(CWK_OPT_ADDR, regv | 16'h0002);
        wait_out(1, 1'b1, 4, n);
        check("discharge start", 16'(n <= 2), T);
        wait_out(1, 1'b0, SHIP + 10, n);
        check("discharge time", 16'(n + 2 >= SHIP && n <= SHIP + 2), T);
        regv[1] = 1'b0;
        rd(CWK_OPT_ADDR);
        wr(CWK_OPT_ADDR, {8'($urandom), 8'h11});
        set_sense(1'b0, 1'b1);
        wait_out(2, 1'b1, 10, n);
        check("wake start", 16'(n <= 6), T);
        wait_out(2, 1'b0, WMS * CPM + 20, n);
        check("wake limit", 16'(n + CPM >= WMS * CPM && n <= WMS * CPM + CPM + 2), T);
        rd(CWK_OPT_ADDR);
        wr(CWK_OPT_ADDR, regv);
        wait_out(2, 1'b1, 10, n);
        check("wake restart", 16'(n <= 6), T);
        set_sense(1'b0, 1'b0);
        wait_out(2, 1'b0, 10, n);
        check("wake stop", 16'(n <= 6), T);
        regv[0] = 1'b0;
        rd(CWK_OPT_ADDR);
        repeat (4) @(posedge clock_i);
        check("reads drained", 16'(exp_q.size()), 16'h0000);
        summarize();
    end
endmodule
